// file: pkg/csip_pkg.sv
// Constants and types for camera status indication and IP configuration
package csip_pkg;
    localparam int CLK_HZ           = 50_000_000;
    localparam int CLK_NS           = 20;
    localparam int MS_CYC           = CLK_HZ / 1000;
    localparam int FLASH_MIN_MS     = 100;
    localparam int SLOW_HALF_MS     = 500;
    localparam int FAST_HALF_MS     = 100;
    localparam int DHCP_WAIT_MS     = 2000;
    localparam int ARP_WAIT_MS      = 200;
    localparam int PAUSE_QUANTUM_NS = 512;
    localparam int FLASH_MIN_CYC    = FLASH_MIN_MS * MS_CYC;
    localparam int SLOW_HALF_CYC    = SLOW_HALF_MS * MS_CYC;
    localparam int FAST_HALF_CYC    = FAST_HALF_MS * MS_CYC;
    localparam int DHCP_WAIT_CYC    = DHCP_WAIT_MS * MS_CYC;
    localparam int ARP_WAIT_CYC     = ARP_WAIT_MS * MS_CYC;
    localparam int PAUSE_QUANTUM_CYC = (PAUSE_QUANTUM_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_W           = 12;
    localparam int INT_W            = 6;
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PERSIST_IP = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_IP_ADDR    = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK   = 12'h014;
    localparam int CTRL_RESTART_BIT = 3;
    localparam int INT_BOUND        = 0;
    localparam int INT_LINK_LOST    = 1;
    localparam int INT_DHCP_TMO     = 2;
    localparam int INT_ARP_CONFLICT = 3;
    localparam int INT_PAUSE        = 4;
    localparam int INT_FATAL        = 5;
    localparam logic [15:0] LLA_PREFIX = 16'hA9FE;
    localparam logic [7:0]  HOST_MIN   = 8'h01;
    localparam logic [7:0]  HOST_MAX   = 8'hFE;
    localparam logic [15:0] LFSR_SEED  = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS  = 16'hB400;
    typedef enum logic [4:0] {
        CSIP_IDLE      = 5'h01,
        CSIP_DHCP_WAIT = 5'h02,
        CSIP_LLA_PICK  = 5'h04,
        CSIP_ARP_WAIT  = 5'h08,
        CSIP_BOUND     = 5'h10
    } csip_state_t;
    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } csip_led_t;
    typedef struct packed {
        logic flow_ctrl_en;
        logic dhcp_en;
        logic persist_en;
    } csip_ctrl_t;
    localparam csip_ctrl_t CTRL_RESET = '{flow_ctrl_en: 1'h1, dhcp_en: 1'h1, persist_en: 1'h0};
endpackage : csip_pkg

// file: hdl/csip_top.sv
// Camera status LEDs, IP address acquisition and PAUSE handling
`timescale 1ns/1ps
module csip_top #(
    parameter int FLASH_MIN_CYC = csip_pkg::FLASH_MIN_CYC,
    parameter int SLOW_HALF_CYC = csip_pkg::SLOW_HALF_CYC,
    parameter int FAST_HALF_CYC = csip_pkg::FAST_HALF_CYC,
    parameter int DHCP_WAIT_CYC = csip_pkg::DHCP_WAIT_CYC,
    parameter int ARP_WAIT_CYC  = csip_pkg::ARP_WAIT_CYC
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          resetn,
    // APB slave
    input  wire logic [csip_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Camera condition inputs
    input  wire logic                          init_busy,
    input  wire logic                          init_done,
    input  wire logic                          fatal_err,
    input  wire logic                          file_xfer,
    input  wire logic                          app_connect,
    input  wire logic                          acq_active,
    input  wire logic                          frame_done,
    // Network port
    input  wire logic                          link_up,
    input  wire logic                          port_activity,
    input  wire logic                          pause_valid,
    input  wire logic [15:0]                   pause_quanta,
    output logic                               tx_halt,
    // Address acquisition
    output logic                               dhcp_req,
    input  wire logic                          dhcp_ack,
    input  wire logic [31:0]                   dhcp_addr,
    output logic                               arp_probe,
    output logic      [31:0]                   arp_addr,
    input  wire logic                          arp_reply,
    output logic      [31:0]                   ip_addr,
    output logic                               app_accept,
    // Indicators and interrupt
    output csip_pkg::csip_led_t                status_led,
    output logic                               led_conn,
    output logic                               led_act,
    output logic                               irq
);
    import csip_pkg::*;

    localparam int BLINK_HALF [2] = '{SLOW_HALF_CYC, FAST_HALF_CYC};

    csip_state_t      state;
    csip_ctrl_t       ctrl;
    logic [31:0]      persist_ip;
    logic [31:0]      tmr;
    logic [15:0]      lfsr;
    logic [1:0]       blink;
    logic [31:0]      flash_hold;
    logic             acq_green;
    logic [31:0]      act_hold;
    logic [15:0]      pause_left;
    logic [4:0]       pause_pre;
    logic [INT_W-1:0] int_st;
    logic [INT_W-1:0] int_mask;
    logic [INT_W-1:0] ev;
    logic             fatal_q;
    logic             restart;
    logic [31:0]      rmux;
    logic             hit;
    logic             err_q;
    logic             setup;
    logic             access;
    logic             wr;

    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign wr      = access & pwrite;
    assign restart = wr && paddr == OFS_CTRL && pwdata[CTRL_RESTART_BIT];

    // Slow and fast blink phases
    for (genvar i = 0; i < 2; i++)
    begin : g_blink
        logic [31:0] cnt;
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                cnt      <= 32'h0;
                blink[i] <= 1'b0;
            end
            else if (cnt == 32'(BLINK_HALF[i] - 1))
            begin
                cnt      <= 32'h0;
                blink[i] <= ~blink[i];
            end
            else
            begin
                cnt <= cnt + 32'h1;
            end
        end
    end

    // Green toggles on frames, spaced by the minimum hold
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flash_hold <= 32'h0;
            acq_green  <= 1'b1;
        end
        else if (!acq_active)
        begin
            flash_hold <= 32'h0;
            acq_green  <= 1'b1;
        end
        else if (frame_done && flash_hold == 32'h0)
        begin
            acq_green  <= ~acq_green;
            flash_hold <= 32'(FLASH_MIN_CYC - 1);
        end
        else if (flash_hold != 32'h0)
        begin
            flash_hold <= flash_hold - 32'h1;
        end
    end

    // Status LED priority selection
    always_comb
    begin
        status_led = '0;
        if (fatal_err)
        begin
            status_led.red  = 1'b1;
            status_led.blue = blink[1];
        end
        else if (!init_done)
        begin
            status_led.red = init_busy ? blink[0] : 1'b1;
        end
        else if (acq_active)
        begin
            status_led.green = acq_green;
        end
        else if (file_xfer)
        begin
            status_led.blue = blink[1];
        end
        else if (state != CSIP_BOUND)
        begin
            status_led.blue = blink[0];
        end
        else if (app_connect)
        begin
            status_led.green = 1'b1;
        end
        else
        begin
            status_led.blue = 1'b1;
        end
    end

    // Connector LEDs
    assign led_conn = link_up;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            act_hold <= 32'h0;
        end
        else if (port_activity)
        begin
            act_hold <= 32'(FAST_HALF_CYC * 2);
        end
        else if (act_hold != 32'h0)
        begin
            act_hold <= act_hold - 32'h1;
        end
    end

    assign led_act = (act_hold != 32'h0) & blink[1];

    // Random source for link-local host part
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lfsr <= LFSR_SEED;
        end
        else
        begin
            lfsr <= (lfsr >> 1) ^ (lfsr[0] ? LFSR_TAPS : 16'h0000);
        end
    end

    // Address acquisition sequence
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state     <= CSIP_IDLE;
            tmr       <= 32'h0;
            ip_addr   <= 32'h0;
            arp_addr  <= 32'h0;
            dhcp_req  <= 1'b0;
            arp_probe <= 1'b0;
        end
        else
        begin
            dhcp_req  <= 1'b0;
            arp_probe <= 1'b0;
            if (tmr != 32'h0)
            begin
                tmr <= tmr - 32'h1;
            end
            if (!link_up || restart)
            begin
                state   <= CSIP_IDLE;
                ip_addr <= 32'h0;
            end
            else
            begin
                unique case (state)
                    CSIP_IDLE:
                    begin
                        if (ctrl.persist_en && persist_ip != 32'h0)
                        begin
                            ip_addr <= persist_ip;
                            state   <= CSIP_BOUND;
                        end
                        else if (ctrl.dhcp_en)
                        begin
                            dhcp_req <= 1'b1;
                            tmr      <= 32'(DHCP_WAIT_CYC - 1);
                            state    <= CSIP_DHCP_WAIT;
                        end
                        else
                        begin
                            state <= CSIP_LLA_PICK;
                        end
                    end
                    CSIP_DHCP_WAIT:
                    begin
                        if (dhcp_ack)
                        begin
                            ip_addr <= dhcp_addr;
                            state   <= CSIP_BOUND;
                        end
                        else if (tmr == 32'h0)
                        begin
                            state <= CSIP_LLA_PICK;
                        end
                    end
                    CSIP_LLA_PICK:
                    begin
                        if (lfsr[15:8] >= HOST_MIN && lfsr[15:8] <= HOST_MAX &&
                            lfsr[7:0] >= HOST_MIN && lfsr[7:0] <= HOST_MAX)
                        begin
                            arp_addr  <= {LLA_PREFIX, lfsr};
                            arp_probe <= 1'b1;
                            tmr       <= 32'(ARP_WAIT_CYC - 1);
                            state     <= CSIP_ARP_WAIT;
                        end
                    end
                    CSIP_ARP_WAIT:
                    begin
                        if (arp_reply)
                        begin
                            state <= CSIP_LLA_PICK;
                        end
                        else if (tmr == 32'h0)
                        begin
                            ip_addr <= arp_addr;
                            state   <= CSIP_BOUND;
                        end
                    end
                    CSIP_BOUND:
                    begin
                        state <= CSIP_BOUND;
                    end
                endcase
            end
        end
    end

    assign app_accept = (state == CSIP_BOUND);

    // PAUSE quanta countdown
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pause_left <= 16'h0000;
            pause_pre  <= 5'h00;
        end
        else if (pause_valid && ctrl.flow_ctrl_en)
        begin
            pause_left <= pause_quanta;
            pause_pre  <= 5'(PAUSE_QUANTUM_CYC - 1);
        end
        else if (pause_left != 16'h0000)
        begin
            if (pause_pre == 5'h00)
            begin
                pause_left <= pause_left - 16'h0001;
                pause_pre  <= 5'(PAUSE_QUANTUM_CYC - 1);
            end
            else
            begin
                pause_pre <= pause_pre - 5'h01;
            end
        end
    end

    assign tx_halt = (pause_left != 16'h0000);

    // Interrupt events
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fatal_q <= 1'b0;
        end
        else
        begin
            fatal_q <= fatal_err;
        end
    end

    always_comb
    begin
        ev                   = '0;
        ev[INT_BOUND]        = state != CSIP_BOUND && link_up && !restart &&
                               ((state == CSIP_DHCP_WAIT && dhcp_ack) ||
                                (state == CSIP_ARP_WAIT && !arp_reply && tmr == 32'h0) ||
                                (state == CSIP_IDLE && ctrl.persist_en && persist_ip != 32'h0));
        ev[INT_LINK_LOST]    = !link_up && state != CSIP_IDLE;
        ev[INT_DHCP_TMO]     = link_up && state == CSIP_DHCP_WAIT && !dhcp_ack && tmr == 32'h0;
        ev[INT_ARP_CONFLICT] = link_up && state == CSIP_ARP_WAIT && arp_reply;
        ev[INT_PAUSE]        = pause_valid && ctrl.flow_ctrl_en;
        ev[INT_FATAL]        = fatal_err && !fatal_q;
    end

    // Sticky status, read clears, set wins
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            int_st <= '0;
        end
        else if (access && !pwrite && paddr == OFS_INT_STATUS)
        begin
            // Clear only the bits returned; an event caught at setup stays
            int_st <= (int_st & ~prdata[INT_W-1:0]) | ev;
        end
        else
        begin
            int_st <= int_st | ev;
        end
    end

    assign irq = |(int_st & int_mask);

    // Register writes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl       <= CTRL_RESET;
            persist_ip <= 32'h0;
            int_mask   <= '0;
        end
        else if (wr)
        begin
            if (paddr == OFS_CTRL)
            begin
                ctrl <= pwdata[$bits(csip_ctrl_t)-1:0];
            end
            if (paddr == OFS_PERSIST_IP)
            begin
                persist_ip <= pwdata;
            end
            if (paddr == OFS_INT_MASK)
            begin
                int_mask <= pwdata[INT_W-1:0];
            end
        end
    end

    // Read mux and decode
    always_comb
    begin
        rmux = 32'h0;
        hit  = 1'b1;
        unique case (paddr)
            OFS_CTRL:       rmux = {29'h0, ctrl};
            OFS_STATUS:     rmux = {22'h0, tx_halt, app_accept, link_up, fatal_err, init_done, 5'(state)};
            OFS_PERSIST_IP: rmux = persist_ip;
            OFS_IP_ADDR:    rmux = ip_addr;
            OFS_INT_STATUS: rmux = {26'h0, int_st};
            OFS_INT_MASK:   rmux = {26'h0, int_mask};
            default:        hit  = 1'b0;
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata <= 32'h0;
            err_q  <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h0 : rmux;
            err_q  <= ~hit;
        end
    end

    assign pready  = access;
    assign pslverr = access & err_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_FATAL_LED: assert property (fatal_err |-> status_led.red && status_led.blue == blink[1])
        else $error("fatal error LED pattern wrong");
    AST_PRIO_ACQ: assert property (!fatal_err && init_done && acq_active |-> !status_led.blue)
        else $error("acquisition lost priority");
    AST_UNINIT_RED: assert property (!fatal_err && !init_done && !init_busy |-> status_led == 3'h4)
        else $error("uninitialized LED not steady red");
    AST_ACCEPT: assert property (app_accept |-> ip_addr != 32'h0)
        else $error("accepting without an address");
    AST_PAUSE: assert property (pause_valid && ctrl.flow_ctrl_en && pause_quanta != 16'h0 |=> tx_halt [*8])
        else $error("pause did not halt transmission");
    AST_FLASH: assert property ($changed(acq_green) && acq_active && $past(acq_active) |-> $past(flash_hold) == 32'h0)
        else $error("green toggled too soon");
    AST_DHCP_ORDER: assert property (dhcp_req |-> ctrl.dhcp_en && $past(state) == CSIP_IDLE)
        else $error("DHCP request out of order");
    AST_LLA_NET: assert property (arp_probe |-> arp_addr[31:16] == LLA_PREFIX)
        else $error("probe outside link-local subnet");
    AST_CONFLICT: assert property (state == CSIP_ARP_WAIT && arp_reply && link_up && !restart |=>
                                   state == CSIP_LLA_PICK ##[1:300] arp_probe)
        else $error("conflict not reprobed");
    AST_LINK_DROP: assert property (!link_up |=> state == CSIP_IDLE && !app_accept)
        else $error("link loss did not restart");
    AST_CONN: assert property ($rose(link_up) |-> led_conn)
        else $error("connection LED missing");
    AST_BOOT: assert property ($rose(resetn) |-> ctrl == CTRL_RESET)
        else $error("defaults wrong after reset");

    COV_DHCP: cover property (state == CSIP_DHCP_WAIT ##1 state == CSIP_BOUND);
    COV_LLA: cover property (state == CSIP_ARP_WAIT ##1 state == CSIP_BOUND);
    COV_CONFLICT: cover property (state == CSIP_ARP_WAIT && arp_reply);
    COV_PAUSE: cover property ($fell(tx_halt));
endmodule : csip_top

// file: test/csip_net_model.sv
// Network partner model: DHCP server and ARP responder
`timescale 1ns/1ps
module csip_net_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Requests from the camera
    input  wire logic        dhcp_req,
    input  wire logic        arp_probe,
    // Scenario controls
    input  wire logic        dhcp_on,
    input  wire logic [31:0] lease,
    input  wire logic [7:0]  conflicts,
    // Answers to the camera and probe count
    output logic             dhcp_ack,
    output logic [31:0]      dhcp_addr,
    output logic             arp_reply,
    output int               probes
);
    logic [3:0] dcnt;
    logic [3:0] acnt;
    // Address lines show no stale lease outside the answer
    assign dhcp_addr = dhcp_ack ? lease : ~lease;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dcnt      <= 4'h0;
            acnt      <= 4'h0;
            dhcp_ack  <= 1'b0;
            arp_reply <= 1'b0;
            probes    <= 0;
        end
        else
        begin
            dhcp_ack  <= (dcnt == 4'h1);
            arp_reply <= (acnt == 4'h1);
            dcnt      <= (dhcp_req && dhcp_on) ? 4'hA : (dcnt != 4'h0) ? dcnt - 4'h1 : 4'h0;
            acnt      <= (arp_probe && probes < conflicts) ? 4'h3 : (acnt != 4'h0) ? acnt - 4'h1 : 4'h0;
            probes    <= probes + (arp_probe ? 1 : 0);
        end
    end
endmodule : csip_net_model

// file: test/test_camera_status_and_ip_config.sv
// Testbench for status LEDs, address acquisition and PAUSE
`timescale 1ns/1ps
module test_camera_status_and_ip_config;
    import csip_pkg::*;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ip_addr, arp_addr, dhcp_addr, lease;
    logic init_busy, init_done, fatal_err, file_xfer, app_connect, acq_active, frame_done;
    logic link_up, port_activity, pause_valid, tx_halt, dhcp_req, dhcp_ack, arp_probe;
    logic arp_reply, app_accept, led_conn, led_act, irq, dhcp_on;
    logic [15:0] pause_quanta;
    logic [7:0] conflicts;
    csip_led_t status_led;
    int fails, check_count, cyc, probes, h;

    csip_top #(.FLASH_MIN_CYC(20), .SLOW_HALF_CYC(40), .FAST_HALF_CYC(8), .DHCP_WAIT_CYC(200),
               .ARP_WAIT_CYC(50)) dut_u (.clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .init_busy, .init_done, .fatal_err, .file_xfer, .app_connect,
        .acq_active, .frame_done, .link_up, .port_activity, .pause_valid, .pause_quanta, .tx_halt,
        .dhcp_req, .dhcp_ack, .dhcp_addr, .arp_probe, .arp_addr, .arp_reply, .ip_addr, .app_accept,
        .status_led, .led_conn, .led_act, .irq);
    csip_net_model net_u (.clk, .resetn, .dhcp_req, .arp_probe, .dhcp_on, .lease,
        .conflicts, .dhcp_ack, .dhcp_addr, .arp_reply, .probes);

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %0t value %h expected %h", $time, s, e);
        end
    endtask : chk

    task finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // One APB transfer, then one idle cycle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Cycles between two changes of one status colour
    task half(input int b, output int n);
        logic v;
        @(posedge clk);
        v = status_led[b];
        while (status_led[b] === v) @(posedge clk);
        v = status_led[b];
        n = 0;
        while (status_led[b] === v)
        begin
            @(posedge clk);
            n++;
        end
    endtask : half

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            fails++;
            finish_test;
        end
    end

    initial
    begin
        {resetn, psel, penable, pwrite, init_busy, init_done, fatal_err, file_xfer} = 8'h00;
        {app_connect, acq_active, frame_done, link_up, port_activity, pause_valid, dhcp_on} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pause_quanta = 16'h0000;
        conflicts = 8'h00;
        lease = 32'hC0A80A05;
        tick(16);
        resetn <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h6);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(slv), 1);
        chk(32'(status_led), 32'h4);
        init_busy <= 1'b1;
        half(2, h);
        chk(h, 40);
        fatal_err <= 1'b1;
        half(0, h);
        chk(h, 8);
        chk(32'(status_led.red), 1);
        fatal_err <= 1'b0;
        init_busy <= 1'b0;
        tick(2);
        chk(32'(status_led), 32'h4);
        init_done <= 1'b1;
        half(0, h);
        chk(h, 40);
        file_xfer <= 1'b1;
        half(0, h);
        chk(h, 8);
        file_xfer <= 1'b0;
        $display("test leds done");
        apb(1'b1, OFS_INT_MASK, 32'h3F);
        chk(32'(app_accept), 0);
        dhcp_on <= 1'b1;
        link_up <= 1'b1;
        while (app_accept !== 1'b1) @(posedge clk);
        tick(1);
        chk(ip_addr, 32'hC0A80A05);
        chk(32'(led_conn), 1);
        chk(32'(status_led), 32'h1);
        chk(32'(irq), 1);
        apb(1'b0, OFS_INT_STATUS, 32'h0);
        chk(32'(rd[INT_BOUND]), 1);
        chk(32'(irq), 0);
        app_connect <= 1'b1;
        tick(2);
        chk(32'(status_led), 32'h2);
        acq_active <= 1'b1;
        fork
            repeat (120) @(posedge clk) frame_done <= ~frame_done;
            half(1, h);
        join
        chk(32'(h >= 20), 1);
        acq_active <= 1'b0;
        app_connect <= 1'b0;
        $display("test dhcp done");
        port_activity <= 1'b1;
        @(posedge clk);
        port_activity <= 1'b0;
        h = 0;
        repeat (20) @(posedge clk) h = h | led_act;
        chk(h, 1);
        tick(40);
        chk(32'(led_act), 0);
        pause_quanta <= 16'h0002;
        pause_valid <= 1'b1;
        @(posedge clk);
        pause_valid <= 1'b0;
        tick(2);
        chk(32'(tx_halt), 1);
        tick(60);
        chk(32'(tx_halt), 0);
        $display("test port done");
        link_up <= 1'b0;
        tick(2);
        chk(ip_addr, 32'h0);
        chk(32'(app_accept), 0);
        chk(32'(led_conn), 0);
        apb(1'b1, OFS_CTRL, 32'h4);
        conflicts <= 8'h01;
        link_up <= 1'b1;
        while (app_accept !== 1'b1) @(posedge clk);
        tick(1);
        chk(probes, 2);
        chk(32'(ip_addr[31:16]), 32'hA9FE);
        chk(32'(ip_addr[7:0] != 8'h00 && ip_addr[7:0] != 8'hFF), 1);
        apb(1'b1, OFS_PERSIST_IP, 32'h0A000007);
        apb(1'b1, OFS_CTRL, 32'hD);
        tick(2);
        while (app_accept !== 1'b1) @(posedge clk);
        tick(1);
        chk(ip_addr, 32'h0A000007);
        chk(probes, 2);
        lease <= 32'hC0A80A09;
        apb(1'b1, OFS_CTRL, 32'hA);
        tick(2);
        while (app_accept !== 1'b1) @(posedge clk);
        tick(1);
        chk(ip_addr, 32'hC0A80A09);
        chk(probes, 2);
        pause_valid <= 1'b1;
        @(posedge clk);
        pause_valid <= 1'b0;
        tick(2);
        chk(32'(tx_halt), 0);
        $display("test address done");
        finish_test;
    end
endmodule : test_camera_status_and_ip_config
